// >>> dbg_pkg.sv
`default_nettype none
package dbg_pkg;
  // ----------------------------------------------------------------
  // Widths and depth
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;

  // ----------------------------------------------------------------
  // Register map in high register space
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FORCE_RESET = 16'h1800;
  localparam logic [ADDR_W-1:0] OFS_CMP_A_HIGH = 16'h1810;
  localparam logic [ADDR_W-1:0] OFS_CMP_A_LOW = 16'h1811;
  localparam logic [ADDR_W-1:0] OFS_CMP_B_HIGH = 16'h1812;
  localparam logic [ADDR_W-1:0] OFS_CMP_B_LOW = 16'h1813;
  localparam logic [ADDR_W-1:0] OFS_FIFO_UPPER = 16'h1814;
  localparam logic [ADDR_W-1:0] OFS_FIFO_LOWER = 16'h1815;

  // ----------------------------------------------------------------
  // Field positions, zero constants and pointer step
  // ----------------------------------------------------------------
  localparam int FORCE_RESET_BIT = 0;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;

  // State of the debug block apart from the trace memory
  typedef struct packed {
    logic [WORD_W-1:0] cmp_a;
    logic [WORD_W-1:0] cmp_b;
    logic [PTR_W-1:0] ptr;
    logic match;
    logic match_fetch;
    logic [ADDR_W-1:0] hit_addr;
    logic force_pend;
    logic tag_valid;
    logic [ADDR_W-1:0] tag_addr;
    logic [ADDR_W-1:0] last_op;
    logic enter;
    logic enter_tagged;
    logic rst_req;
    logic [BYTE_W-1:0] rdata;
    logic rvalid;
  } dbg_state_t;
endpackage : dbg_pkg
`default_nettype wire

// >>> trace_mem_if.sv
`default_nettype none
interface trace_mem_if #(
  parameter int DW = 16,
  parameter int AW = 3
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : trace_mem_if
`default_nettype wire

// >>> trace_mem.sv
`default_nettype none
module trace_mem #(
  parameter int DW = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic mclk,
  input wire logic reset,
  trace_mem_if.mem port
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  // ----------------------------------------------------------------
  // Storage and registered read
  // ----------------------------------------------------------------
  // Write first on a collision so the reader never sees a stale word
  always_ff @(posedge mclk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
    if (reset) begin
      rdata_q <= '0;
    end else if (port.we && port.waddr == port.raddr) begin
      rdata_q <= port.wdata;
    end else begin
      rdata_q <= mem_q[port.raddr];
    end
  end

  assign port.rdata = rdata_q;
endmodule : trace_mem
`default_nettype wire

// >>> dbg_breakpoint.sv
// Operation
// - Compare each CPU bus address with the 16-bit match value; equal requests a breakpoint.
// - Forced type: enter background mode at the next instruction boundary after access.
// - Tagged type: mark matching opcode, enter background when it reaches queue end.
// - Enable bit, reset to 0, gates every breakpoint request.
// - Select bit 1 picks forced type, 0 picks tagged type.
// - Background write of 1 to bit 0 of force-reset register resets the chip.
// - Normal bus writes never set the force-reset bit.
// - Comparator and trace registers sit in high register space, open to application code.
// - Comparator bytes reset to 0x00, always readable, writes ignored while armed.
// - FIFO upper byte is read-only and reading it does not advance the FIFO.
// - Event-only modes store low bytes only; upper byte reads 0x00.
// - FIFO lower-byte read returns low half, then advances; writes ignored.
// - While armed, lower-byte reads do not advance the FIFO.
// - Unarmed lower-byte read stores latest opcode address into last FIFO slot.
// - FIFO is eight deep; ninth unarmed read returns the opcode address the first read stored.
`default_nettype none
module dbg_breakpoint (
  input wire logic mclk,
  input wire logic reset,
  // CPU side
  input wire logic [dbg_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_valid,
  input wire logic opcode_fetch,
  input wire logic instr_boundary,
  input wire logic queue_end,
  input wire logic [dbg_pkg::ADDR_W-1:0] queue_end_addr,
  output logic bkgd_enter,
  output logic bkgd_tagged,
  // Background controller settings
  input wire logic [dbg_pkg::ADDR_W-1:0] breakpoint_match_value,
  input wire logic breakpoint_logic_enable,
  input wire logic force_or_tag_select,
  // Serial background write commands
  input wire logic bgnd_wr,
  input wire logic [dbg_pkg::ADDR_W-1:0] bgnd_addr,
  input wire logic [dbg_pkg::BYTE_W-1:0] bgnd_wdata,
  output logic mcu_reset_req,
  // Debug module state from its trigger logic
  input wire logic capture_active_flag,
  input wire logic event_only,
  input wire logic capture_valid,
  input wire logic [dbg_pkg::WORD_W-1:0] capture_data,
  // Normal CPU register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dbg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dbg_pkg::BYTE_W-1:0] reg_wdata,
  output logic [dbg_pkg::BYTE_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic [dbg_pkg::WORD_W-1:0] comparator_a,
  output logic [dbg_pkg::WORD_W-1:0] comparator_b
);
  import dbg_pkg::*;

  dbg_state_t s_q;
  dbg_state_t s_d;
  logic wr_ok;
  logic fl_rd;
  logic tag_hit;

  trace_mem_if #(.DW(WORD_W), .AW(PTR_W)) mif ();

  // ----------------------------------------------------------------
  // Trace storage
  // ----------------------------------------------------------------
  trace_mem #(.DW(WORD_W), .DEPTH(FIFO_DEPTH), .AW(PTR_W)) u_mem (
    .mclk(mclk),
    .reset(reset),
    .port(mif.mem)
  );

  // Helper terms for the next-state logic
  assign wr_ok = reg_wr && !capture_active_flag;
  assign fl_rd = reg_rd && reg_addr == OFS_FIFO_LOWER;
  assign tag_hit = queue_end && s_q.tag_valid && queue_end_addr == s_q.tag_addr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.enter = 1'b0;
    s_d.enter_tagged = 1'b0;
    s_d.rst_req = 1'b0;
    s_d.rvalid = 1'b0;
    mif.we = 1'b0;
    mif.waddr = s_q.ptr;
    mif.wdata = WORD_ZERO;

    // Address compare each bus cycle, used one cycle later for timing
    s_d.match = breakpoint_logic_enable && bus_valid
                && bus_addr == breakpoint_match_value;
    s_d.match_fetch = opcode_fetch;
    s_d.hit_addr = bus_addr;
    if (bus_valid && opcode_fetch) begin
      s_d.last_op = bus_addr;
    end

    // Forced entry waits for the boundary; a new match in that cycle rearms
    if (instr_boundary && s_q.force_pend) begin
      s_d.enter = 1'b1;
      s_d.force_pend = 1'b0;
    end
    if (s_q.match && force_or_tag_select) begin
      s_d.force_pend = 1'b1;
    end

    // Tagged entry replaces execution of the marked opcode
    if (tag_hit) begin
      s_d.enter = 1'b1;
      s_d.enter_tagged = 1'b1;
      s_d.tag_valid = 1'b0;
    end
    if (s_q.match && !force_or_tag_select && s_q.match_fetch) begin
      s_d.tag_valid = 1'b1;
      s_d.tag_addr = s_q.hit_addr;
    end

    // Disabled logic drops everything pending and requests nothing
    if (!breakpoint_logic_enable) begin
      s_d.force_pend = 1'b0;
      s_d.tag_valid = 1'b0;
      s_d.enter = 1'b0;
      s_d.enter_tagged = 1'b0;
    end

    // Only the serial background path can reach the reset bit
    if (bgnd_wr && bgnd_addr == OFS_FORCE_RESET && bgnd_wdata[FORCE_RESET_BIT]) begin
      s_d.rst_req = 1'b1;
    end

    // Comparator writes; trace bytes are read-only
    if (wr_ok) begin
      unique case (reg_addr)
        OFS_CMP_A_HIGH: s_d.cmp_a[WORD_W-1:BYTE_W] = reg_wdata;
        OFS_CMP_A_LOW: s_d.cmp_a[BYTE_W-1:0] = reg_wdata;
        OFS_CMP_B_HIGH: s_d.cmp_b[WORD_W-1:BYTE_W] = reg_wdata;
        OFS_CMP_B_LOW: s_d.cmp_b[BYTE_W-1:0] = reg_wdata;
        default: ;
      endcase
    end

    // Register reads; unmapped addresses answer zero
    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      unique case (reg_addr)
        OFS_CMP_A_HIGH: s_d.rdata = s_q.cmp_a[WORD_W-1:BYTE_W];
        OFS_CMP_A_LOW: s_d.rdata = s_q.cmp_a[BYTE_W-1:0];
        OFS_CMP_B_HIGH: s_d.rdata = s_q.cmp_b[WORD_W-1:BYTE_W];
        OFS_CMP_B_LOW: s_d.rdata = s_q.cmp_b[BYTE_W-1:0];
        OFS_FIFO_UPPER: s_d.rdata = event_only ? BYTE_ZERO
                                    : mif.rdata[WORD_W-1:BYTE_W];
        OFS_FIFO_LOWER: s_d.rdata = mif.rdata[BYTE_W-1:0];
        default: s_d.rdata = BYTE_ZERO;
      endcase
    end

    // Unarmed low read: profile the last opcode into the slot just left
    if (fl_rd && !capture_active_flag) begin
      mif.we = 1'b1;
      mif.wdata = s_q.last_op;
      s_d.ptr = s_q.ptr + PTR_ONE;
    end

    // Armed capture; reads then leave the pointer alone
    if (capture_active_flag && capture_valid) begin
      mif.we = 1'b1;
      mif.wdata = event_only ? {BYTE_ZERO, capture_data[BYTE_W-1:0]}
                  : capture_data;
      s_d.ptr = s_q.ptr + PTR_ONE;
    end
  end

  // Read address follows the next pointer so the word is ready on time
  assign mif.raddr = s_d.ptr;

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign bkgd_enter = s_q.enter;
  assign bkgd_tagged = s_q.enter_tagged;
  assign mcu_reset_req = s_q.rst_req;
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign comparator_a = s_q.cmp_a;
  assign comparator_b = s_q.cmp_b;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_match_registered: assert property (
    breakpoint_logic_enable && bus_valid && bus_addr == breakpoint_match_value
    |=> s_q.match)
    else $error("address match not registered");

  chk_disabled_quiet: assert property (
    !breakpoint_logic_enable |=> !bkgd_enter && !s_q.force_pend && !s_q.tag_valid)
    else $error("breakpoint active while disabled");

  chk_forced_entry: assert property (
    breakpoint_logic_enable && s_q.match && force_or_tag_select
    ##1 breakpoint_logic_enable && instr_boundary |=> bkgd_enter && !bkgd_tagged)
    else $error("forced breakpoint did not enter background");

  chk_tagged_entry: assert property (
    breakpoint_logic_enable && tag_hit |=> bkgd_enter && bkgd_tagged)
    else $error("tagged breakpoint did not enter background");

  chk_tag_type: assert property (
    s_q.match && !force_or_tag_select && breakpoint_logic_enable |=> !s_q.force_pend
    or $past(s_q.force_pend))
    else $error("tagged select armed a forced breakpoint");

  chk_force_reset: assert property (
    bgnd_wr && bgnd_addr == OFS_FORCE_RESET && bgnd_wdata[FORCE_RESET_BIT]
    |=> mcu_reset_req ##1 !mcu_reset_req or mcu_reset_req)
    else $error("force reset request missing");

  chk_user_no_reset: assert property (
    !bgnd_wr |=> !mcu_reset_req)
    else $error("reset raised without background write");

  chk_cmp_locked: assert property (
    reg_wr && capture_active_flag |=> $stable(comparator_a) && $stable(comparator_b))
    else $error("comparator written while armed");

  chk_upper_no_adv: assert property (
    reg_rd && reg_addr == OFS_FIFO_UPPER && !capture_active_flag |=> $stable(s_q.ptr))
    else $error("upper byte read advanced fifo");

  chk_event_upper_zero: assert property (
    reg_rd && reg_addr == OFS_FIFO_UPPER && event_only |=> reg_rvalid && reg_rdata == BYTE_ZERO)
    else $error("upper byte not zero in event-only mode");

  chk_lower_advance: assert property (
    fl_rd && !capture_active_flag |=> s_q.ptr == $past(s_q.ptr) + PTR_ONE)
    else $error("lower byte read did not advance fifo");

  chk_armed_hold: assert property (
    fl_rd && capture_active_flag && !capture_valid |=> $stable(s_q.ptr))
    else $error("fifo advanced on armed read");

  // ----------------------------------------------------------------
  // Path checks
  // ----------------------------------------------------------------
  // Breakpoint path: every entry must trace back to a pending cause
  chk_match_gated: assert property (
    !breakpoint_logic_enable
    |=> !s_q.match)
    else $error("match registered while disabled");

  chk_force_armed: assert property (
    breakpoint_logic_enable && s_q.match && force_or_tag_select
    |=> s_q.force_pend)
    else $error("forced match not made pending");

  chk_tag_armed: assert property (
    breakpoint_logic_enable && s_q.match && !force_or_tag_select && s_q.match_fetch
    |=> s_q.tag_valid && s_q.tag_addr == $past(s_q.hit_addr))
    else $error("opcode match not tagged");

  chk_tag_needs_fetch: assert property (
    s_q.match && !s_q.match_fetch && !s_q.tag_valid
    |=> !s_q.tag_valid)
    else $error("data access match tagged an opcode");

  chk_enter_cause: assert property (
    !(instr_boundary && s_q.force_pend) && !tag_hit
    |=> !bkgd_enter)
    else $error("background entry without a cause");

  chk_forced_source: assert property (
    bkgd_enter && !bkgd_tagged
    |-> $past(s_q.force_pend) && $past(instr_boundary))
    else $error("forced entry without pending boundary");

  // Register path: the normal bus never reaches the reset bit
  chk_user_reset_write: assert property (
    reg_wr && reg_addr == OFS_FORCE_RESET && !bgnd_wr
    |=> !mcu_reset_req)
    else $error("normal bus write raised reset");

  chk_cmp_a_write: assert property (
    reg_wr && !capture_active_flag && reg_addr == OFS_CMP_A_LOW
    |=> comparator_a[BYTE_W-1:0] == $past(reg_wdata))
    else $error("comparator a low byte write lost");

  chk_cmp_b_write: assert property (
    reg_wr && !capture_active_flag && reg_addr == OFS_CMP_B_HIGH
    |=> comparator_b[WORD_W-1:BYTE_W] == $past(reg_wdata))
    else $error("comparator b high byte write lost");

  chk_read_answer: assert property (
    reg_rd
    |=> reg_rvalid)
    else $error("register read not answered");

  chk_cmp_readback: assert property (
    reg_rd && reg_addr == OFS_CMP_A_HIGH
    |=> reg_rdata == $past(comparator_a[WORD_W-1:BYTE_W]))
    else $error("comparator a high byte read wrong");

  // Trace path: pointer moves only on captures and unarmed low reads
  chk_profile_store: assert property (
    fl_rd && !capture_active_flag
    |-> mif.we && mif.waddr == s_q.ptr && mif.wdata == s_q.last_op)
    else $error("profile address not stored");

  chk_lower_write_ignored: assert property (
    reg_wr && reg_addr == OFS_FIFO_LOWER && !reg_rd && !capture_valid
    |=> $stable(s_q.ptr))
    else $error("write to lower byte moved fifo");

  chk_capture_advance: assert property (
    capture_active_flag && capture_valid
    |=> s_q.ptr == $past(s_q.ptr) + PTR_ONE)
    else $error("armed capture did not advance fifo");

  chk_event_low_only: assert property (
    capture_active_flag && capture_valid && event_only
    |-> mif.wdata[WORD_W-1:BYTE_W] == BYTE_ZERO)
    else $error("event-only capture kept upper byte");

  cov_forced: cover property (s_q.force_pend ##[1:20] bkgd_enter && !bkgd_tagged);
  cov_tagged: cover property (s_q.tag_valid ##[1:20] bkgd_enter && bkgd_tagged);
  cov_profile: cover property (fl_rd && !capture_active_flag ##1 fl_rd);
  cov_reset_cmd: cover property (mcu_reset_req);
  cov_event_capture: cover property (capture_active_flag && capture_valid && event_only);
endmodule : dbg_breakpoint
`default_nettype wire

// >>> cpu_bus_model.sv
`default_nettype none
// CPU core seen by the breakpoint: fetch, data access, idle, then boundary
module cpu_bus_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [dbg_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic [dbg_pkg::ADDR_W-1:0] data_addr,
  output logic [dbg_pkg::ADDR_W-1:0] bus_addr,
  output logic bus_valid,
  output logic opcode_fetch,
  output logic instr_boundary,
  output logic queue_end,
  output logic [dbg_pkg::ADDR_W-1:0] queue_end_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbg_pkg::*;
  int step = 0;
  initial begin
    bus_addr = '0;
    queue_end_addr = '0;
    bus_valid = 1'b0;
    opcode_fetch = 1'b0;
    instr_boundary = 1'b0;
    queue_end = 1'b0;
  end
  // Sequencer advances on the rising edge
  always @(posedge mclk) begin
    if (step == 4) step <= 0;
    else if (step != 0 || go) step <= step + 1;
  end
  // Bus moves at the falling edge; an idle bus toggles the address between its last value and its inverse
  always @(negedge mclk) begin
    bus_valid <= (step == 1 || step == 2);
    opcode_fetch <= (step == 1);
    instr_boundary <= (step == 4);
    queue_end <= (step == 4);
    bus_addr <= (step == 1) ? fetch_addr : (step == 2) ? data_addr : ~bus_addr;
    queue_end_addr <= (step == 4) ? fetch_addr : ~queue_end_addr;
  end
endmodule : cpu_bus_model
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dbg_pkg::*;
  localparam logic [15:0] OP_A = 16'h2345;
  localparam logic [15:0] OP_B = 16'h3456;
  localparam logic [15:0] DATA_D = 16'h0081;
  logic mclk, reset, bus_valid, opcode_fetch, instr_boundary, queue_end, go;
  logic bkgd_enter, bkgd_tagged, en, force_sel, bgnd_wr, mcu_reset_req, armed, event_only;
  logic capture_valid, reg_wr, reg_rd, reg_rvalid, last_tag;
  logic [15:0] bus_addr, queue_end_addr, match_value, bgnd_addr, capture_data, reg_addr;
  logic [15:0] comparator_a, comparator_b, fetch_addr;
  logic [7:0] bgnd_wdata, reg_wdata, reg_rdata;
  int miscompares = 0, samples_checked = 0, enters = 0, resets = 0, cycles = 0, n;
  // Breakpoint cases: enable, type select, match value, entries, tagged
  logic bp_en [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic bp_force [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [15:0] bp_val [5] = '{DATA_D, DATA_D, OP_A, DATA_D, OP_A + 16'h1};
  int bp_n [5] = '{0, 1, 1, 0, 0};
  logic [7:0] cv [4] = '{8'h12, 8'h34, 8'h56, 8'h78};

  cpu_bus_model u_cpu (.mclk(mclk), .go(go), .fetch_addr(fetch_addr), .data_addr(DATA_D),
    .bus_addr(bus_addr), .bus_valid(bus_valid), .opcode_fetch(opcode_fetch),
    .instr_boundary(instr_boundary), .queue_end(queue_end), .queue_end_addr(queue_end_addr));
  dbg_breakpoint u_dut (.mclk(mclk), .reset(reset), .bus_addr(bus_addr),
    .bus_valid(bus_valid), .opcode_fetch(opcode_fetch), .instr_boundary(instr_boundary),
    .queue_end(queue_end), .queue_end_addr(queue_end_addr), .bkgd_enter(bkgd_enter),
    .bkgd_tagged(bkgd_tagged), .breakpoint_match_value(match_value),
    .breakpoint_logic_enable(en), .force_or_tag_select(force_sel), .bgnd_wr(bgnd_wr),
    .bgnd_addr(bgnd_addr), .bgnd_wdata(bgnd_wdata), .mcu_reset_req(mcu_reset_req),
    .capture_active_flag(armed), .event_only(event_only), .capture_valid(capture_valid),
    .capture_data(capture_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .comparator_a(comparator_a), .comparator_b(comparator_b));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Pulse counters and hang guard, all on the rising edge
  always @(posedge mclk) begin
    cycles++;
    if (bkgd_enter === 1'b1) begin
      enters++;
      last_tag = bkgd_tagged;
    end
    if (mcu_reset_req === 1'b1) resets++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One-cycle read; answer stands in the following cycle only
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    check("reg_rdata", {reg_rvalid, 7'h0, reg_rdata}, {1'b1, 7'h0, exp});
  endtask : rd

  task automatic wr(input logic bgnd, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    if (bgnd) {bgnd_wr, bgnd_addr, bgnd_wdata} = {1'b1, a, d};
    else {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge mclk);
    bgnd_wr = 1'b0;
    reg_wr = 1'b0;
  endtask : wr

  task automatic run(input logic [15:0] f);
    @(negedge mclk);
    fetch_addr = f;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    repeat (8) @(negedge mclk);
  endtask : run

  initial begin
    {reset, go, en, force_sel, bgnd_wr, armed, event_only, capture_valid, reg_wr, reg_rd} = 10'h200;
    {match_value, bgnd_addr, capture_data, reg_addr, fetch_addr} = '0;
    {bgnd_wdata, reg_wdata} = '0;
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    for (int i = 0; i < 4; i++) rd(OFS_CMP_A_HIGH + 16'(i), 8'h00);
    for (int i = 0; i < 4; i++) wr(1'b0, OFS_CMP_A_HIGH + 16'(i), cv[i]);
    for (int i = 0; i < 4; i++) rd(OFS_CMP_A_HIGH + 16'(i), cv[i]);
    check("comparator_a", comparator_a, 16'h1234);
    check("comparator_b", comparator_b, 16'h5678);
    armed = 1'b1;
    wr(1'b0, OFS_CMP_B_LOW, 8'hff);
    rd(OFS_CMP_B_LOW, 8'h78);
    // Armed captures fill all eight slots
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk);
      capture_valid = 1'b1;
      capture_data = {8'h10 + 8'(i), 8'h80 + 8'(i)};
    end
    @(negedge mclk);
    capture_valid = 1'b0;
    rd(OFS_FIFO_LOWER, 8'h80);
    rd(OFS_FIFO_LOWER, 8'h80);
    armed = 1'b0;
    wr(1'b0, OFS_FIFO_UPPER, 8'hff);
    wr(1'b0, OFS_FIFO_LOWER, 8'hff);
    run(OP_A);
    // Upper byte first, read twice to show it does not advance
    for (int i = 0; i < 8; i++) begin
      rd(OFS_FIFO_UPPER, 8'h10 + 8'(i));
      rd(OFS_FIFO_UPPER, 8'h10 + 8'(i));
      rd(OFS_FIFO_LOWER, 8'h80 + 8'(i));
      if (i == 0) run(OP_B);
    end
    // Second lap shows what each earlier read stored
    for (int i = 0; i < 8; i++) begin
      rd(OFS_FIFO_UPPER, (i == 0) ? OP_A[15:8] : OP_B[15:8]);
      rd(OFS_FIFO_LOWER, (i == 0) ? OP_A[7:0] : OP_B[7:0]);
    end
    // Event-only captures wrap the fifo; only low bytes may be kept
    {armed, event_only} = 2'h3;
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk);
      capture_valid = 1'b1;
      capture_data = {8'haa, 8'hc0 + 8'(i)};
    end
    @(negedge mclk);
    {armed, event_only, capture_valid} = 3'h0;
    rd(OFS_FIFO_UPPER, 8'h00);
    rd(OFS_FIFO_LOWER, 8'hc0);
    event_only = 1'b1;
    rd(OFS_FIFO_UPPER, 8'h00);
    event_only = 1'b0;
    rd(16'h1816, 8'h00);
    wr(1'b1, OFS_FORCE_RESET, 8'h01);
    wr(1'b1, OFS_FORCE_RESET, 8'h00);
    wr(1'b1, OFS_CMP_A_LOW, 8'h01);
    wr(1'b0, OFS_FORCE_RESET, 8'h01);
    repeat (2) @(negedge mclk);
    check("mcu_reset_req count", 16'(resets), 16'h1);
    rd(OFS_CMP_A_LOW, 8'h34);
    // Tagged cases match on the opcode address and on the data address; only the opcode match enters
    for (int i = 0; i < 5; i++) begin
      {en, force_sel, match_value} = {bp_en[i], bp_force[i], bp_val[i]};
      n = enters;
      run(OP_A);
      check("bkgd_enter count", 16'(enters - n), 16'(bp_n[i]));
      if (bp_n[i] == 1) check("bkgd_tagged", {15'h0, last_tag}, {15'h0, ~bp_force[i]});
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
